// [logic/ras_top.sv]
// Return address stack: index pointer, save and restore control.
// Assumes call, interrupt, table and return strobes come from core
// sequencing logic on i_clk, one cycle each.
//
// Notes on behaviour
// - Entry read or written is chosen only by the stack pointer value.
// - A subroutine call stores its return address in the pointed entry.
// - An accepted interrupt stores the interrupted address likewise.
// - Table reference parks the program counter in an entry, then restores.
// - Sixteen index positions 0H to FH, each entry sixteen bits wide.
// - Index FH has no storage; reading it gives the fixed value 0000H.
// - The pointer is a four-bit binary counter over all sixteen positions.
// - The pointer can be read and written directly by instructions.
`timescale 1ns/1ps
`include "ras_regs.svh"

module ras_top #(
    parameter int DEPTH = `RAS_DEPTH
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_call,
    input  wire logic              i_irq_accept,
    input  wire logic              i_table_ref,
    input  wire logic              i_table_done,
    input  wire logic              i_ret,
    input  wire logic              i_ptr_write,
    input  wire ras_pkg::ras_ptr_t  i_ptr_wdata,
    input  wire ras_pkg::ras_addr_t i_return_addr,
    output ras_pkg::ras_ptr_t      o_entry_index_pointer,
    output ras_pkg::ras_addr_t     o_pc_value,
    output logic                   o_pc_load,
    output logic                   o_table_busy
);
    import ras_pkg::*;

    ras_file_if file_bus ();

    ras_ptr_t   entry_index_pointer;
    ras_ptr_t   next_entry_index_pointer;
    ras_state_t state;
    ras_state_t next_state;
    ras_addr_t  pc_value;
    logic       pc_load;
    logic       table_start;
    logic       table_end;
    logic       push_req;
    logic       pop_req;
    logic       push_go;
    logic       pop_go;

    // Table reference opens only from idle and closes only inside it
    assign table_start = i_table_ref && (state == RAS_IDLE);
    assign table_end   = i_table_done && (state == RAS_TABLE);

    // Save and restore requests; direct pointer write has priority,
    // then restore, then save
    assign push_req = i_call || i_irq_accept || table_start;
    assign pop_req  = i_ret || table_end;
    assign pop_go   = pop_req && !i_ptr_write;
    assign push_go  = push_req && !i_ptr_write && !pop_req;

    // Next pointer: four-bit binary counter that wraps FH to 0H
    always_comb begin
        if (i_ptr_write) begin
            next_entry_index_pointer = i_ptr_wdata;
        end else if (pop_go) begin
            next_entry_index_pointer =
                entry_index_pointer - `RAS_PTR_STEP;
        end else if (push_go) begin
            next_entry_index_pointer =
                entry_index_pointer + `RAS_PTR_STEP;
        end else begin
            next_entry_index_pointer = entry_index_pointer;
        end
    end

    // Pointer register
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            entry_index_pointer <= `RAS_PTR_RESET;
        end else begin
            entry_index_pointer <= next_entry_index_pointer;
        end
    end

    // Save goes to the entry the pointer moves onto
    assign file_bus.wr_en   = push_go;
    assign file_bus.wr_idx  = next_entry_index_pointer;
    assign file_bus.wr_data = i_return_addr;
    // Read always at the current pointer
    assign file_bus.rd_idx  = entry_index_pointer;

    ras_file #(
        .DEPTH (DEPTH)
    ) u_file (
        .i_clk   (i_clk),
        .port_io (file_bus.store)
    );

    // Table reference sequencing
    always_comb begin
        next_state = state;
        case (state)
            RAS_IDLE: begin
                if (table_start && push_go) begin
                    next_state = RAS_TABLE;
                end
            end
            RAS_TABLE: begin
                if (table_end && pop_go) begin
                    next_state = RAS_IDLE;
                end
            end
            default: begin
                next_state = RAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state <= RAS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Program counter restore from the pointed entry
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pc_value <= `RAS_PC_RESET;
            pc_load  <= 1'b0;
        end else begin
            pc_load <= pop_go;
            if (pop_go) begin
                pc_value <= file_bus.rd_data;
            end
        end
    end

    assign o_entry_index_pointer = entry_index_pointer;
    assign o_pc_value            = pc_value;
    assign o_pc_load             = pc_load;
    assign o_table_busy          = (state == RAS_TABLE);

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_call;
        i_call && push_go && (next_entry_index_pointer != `RAS_TOP_INDEX);
    endsequence

    sequence s_irq;
        i_irq_accept && !i_call && push_go
            && (next_entry_index_pointer != `RAS_TOP_INDEX);
    endsequence

    sequence s_table_open;
        table_start && push_go
            && (next_entry_index_pointer != `RAS_TOP_INDEX);
    endsequence

    sequence s_restore;
        pop_go;
    endsequence

    property p_index;
        file_bus.rd_idx == entry_index_pointer
            && (!push_go || file_bus.wr_idx == next_entry_index_pointer);
    endproperty
    a_index: assert property (p_index)
        else $error("stack index differs from pointer");

    property p_call_store;
        s_call |=> file_bus.rd_data == $past(i_return_addr)
            && entry_index_pointer == $past(entry_index_pointer) + 4'h1;
    endproperty
    a_call_store: assert property (p_call_store)
        else $error("call did not store return address");

    property p_irq_store;
        s_irq |=> file_bus.rd_data == $past(i_return_addr);
    endproperty
    a_irq_store: assert property (p_irq_store)
        else $error("interrupt did not store return address");

    property p_table;
        s_table_open |=> o_table_busy
            && file_bus.rd_data == $past(i_return_addr);
    endproperty
    a_table: assert property (p_table)
        else $error("table reference did not park program counter");

    property p_wrap;
        (push_go && entry_index_pointer == `RAS_TOP_INDEX)
            |=> entry_index_pointer == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("pointer did not wrap over sixteen positions");

    property p_undef;
        entry_index_pointer == `RAS_TOP_INDEX
            |-> file_bus.rd_data == `RAS_UNDEF_VALUE;
    endproperty
    a_undef: assert property (p_undef)
        else $error("top index read not the fixed value");

    property p_hold;
        !i_ptr_write && !push_req && !pop_req ##1 !i_ptr_write
            && !push_req && !pop_req |-> $stable(entry_index_pointer);
    endproperty
    a_hold: assert property (p_hold)
        else $error("pointer moved without a request");

    property p_ptr_write;
        i_ptr_write |=> o_entry_index_pointer == $past(i_ptr_wdata)
            && !o_pc_load;
    endproperty
    a_ptr_write: assert property (p_ptr_write)
        else $error("direct pointer write not taken");

    property p_restore;
        s_restore |=> o_pc_load && o_pc_value == $past(file_bus.rd_data)
            && entry_index_pointer == $past(entry_index_pointer) - 4'h1;
    endproperty
    a_restore: assert property (p_restore)
        else $error("return did not restore from pointed entry");

endmodule

// [include/ras_regs.svh]
// Constants of the return address stack: widths, indices, reset values.
// Assumes inclusion by bare name from packages and modules.
`ifndef RAS_REGS_SVH
`define RAS_REGS_SVH

// Width of one stored return address
`define RAS_ENTRY_WIDTH   16
// Number of index positions the pointer can reach
`define RAS_DEPTH         16
// Width of the index pointer
`define RAS_PTR_WIDTH     4
// Pointer after reset: top index, so the first save lands in entry 0
`define RAS_PTR_RESET     4'hF
// Index with no storage behind it
`define RAS_TOP_INDEX     4'hF
// Value returned when the top index is read
`define RAS_UNDEF_VALUE   16'h0000
// Step of the pointer on a save or restore
`define RAS_PTR_STEP      4'h1
// Program counter value after reset
`define RAS_PC_RESET      16'h0000

`endif

// [include/ras_pkg.sv]
// Types shared by the return address stack modules.
// Assumes ras_regs.svh is on the include path.
`include "ras_regs.svh"

package ras_pkg;

    typedef logic [`RAS_ENTRY_WIDTH-1:0] ras_addr_t;
    typedef logic [`RAS_PTR_WIDTH-1:0]   ras_ptr_t;

    // Sequencing state, one-hot
    typedef enum logic [1:0] {
        RAS_IDLE  = 2'b01,
        RAS_TABLE = 2'b10
    } ras_state_t;

endpackage

// [include/ras_file_if.sv]
// Interface between the stack control and the entry storage.
// Assumes ras_pkg is compiled first; single clock domain.
`timescale 1ns/1ps

interface ras_file_if;
    import ras_pkg::*;

    logic      wr_en;
    ras_ptr_t  wr_idx;
    ras_addr_t wr_data;
    ras_ptr_t  rd_idx;
    ras_addr_t rd_data;

    modport ctrl  (output wr_en, output wr_idx, output wr_data,
                   output rd_idx, input rd_data);
    modport store (input wr_en, input wr_idx, input wr_data,
                   input rd_idx, output rd_data);
endinterface

// [logic/ras_file.sv]
// Storage of the return entries, indexed by the stack pointer.
// Assumes write requests come from ras_top on the same clock.
`timescale 1ns/1ps
`include "ras_regs.svh"

module ras_file #(
    parameter int DEPTH = `RAS_DEPTH
) (
    input  wire logic  i_clk,
    ras_file_if.store  port_io
);
    import ras_pkg::*;

    // Only DEPTH-1 entries are backed; the top index has none
    ras_addr_t return_entry [DEPTH-1];

    // One write port per backed entry
    genvar g;
    generate
        for (g = 0; g < DEPTH - 1; g++) begin : g_entry
            always_ff @(posedge i_clk) begin
                if (port_io.wr_en && port_io.wr_idx == ras_ptr_t'(g)) begin
                    return_entry[g] <= port_io.wr_data;
                end
            end
        end
    endgenerate

    // Read selected purely by index; top index reads a fixed value
    always_comb begin
        if (port_io.rd_idx == `RAS_TOP_INDEX) begin
            port_io.rd_data = `RAS_UNDEF_VALUE;
        end else begin
            port_io.rd_data = return_entry[port_io.rd_idx];
        end
    end

endmodule

// [sim/ras_core_model.sv]
// Core sequencing model: turns a bench op code into one-cycle strobes.
// Assumes op codes change just after a rising edge of i_clk.
`timescale 1ns/1ps

module ras_core_model (
    input  wire logic        i_clk,
    input  wire logic [2:0]  i_op,
    input  wire logic [15:0] i_addr,
    input  wire logic [3:0]  i_wdata,
    output logic             o_call,
    output logic             o_irq,
    output logic             o_tref,
    output logic             o_tdone,
    output logic             o_ret,
    output logic             o_pwr,
    output logic [15:0]      o_addr,
    output logic [3:0]       o_wdata
);
    // Idle outputs at time zero
    initial begin
        {o_call, o_irq, o_tref, o_tdone, o_ret, o_pwr} = 6'h00;
        o_addr = 16'h0000;
        o_wdata = 4'h0;
    end

    // Strobes for one cycle; address scrambled for every op but 1, 2 and 3, so also for op 7
    always @(posedge i_clk) begin
        o_call  <= (i_op == 3'h1) || (i_op == 3'h7);
        o_irq   <= (i_op == 3'h2);
        o_tref  <= (i_op == 3'h3);
        o_tdone <= (i_op == 3'h4);
        o_ret   <= (i_op == 3'h5) || (i_op == 3'h7);
        o_pwr   <= (i_op == 3'h6);
        o_addr  <= (i_op inside {3'h1, 3'h2, 3'h3}) ? i_addr : ~o_addr;
        o_wdata <= (i_op == 3'h6) ? i_wdata : ~o_wdata;
    end
endmodule

// [sim/tb_top.sv]
// Self-checking bench of the return address stack with a reference stack.
// Assumes ras_top and ras_core_model are compiled before it.
`timescale 1ns/1ps

module tb_top;
    import ras_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [2:0] op = 3'h0;
    logic [15:0] addr = 16'h0000;
    logic [3:0] wd = 4'h0;
    logic c, q, tr, td, r, pw;
    logic [15:0] ma;
    logic [3:0] mw;
    ras_ptr_t ptr_o;
    ras_addr_t pc_o;
    logic ld_o, busy_o;
    int fails = 0;
    int comparisons = 0;
    logic [15:0] mem [16];
    bit vld [16];
    logic [3:0] ptr = 4'hF;
    logic [15:0] pcv = 16'h0000;
    bit busy = 0;

    // Clock of 100 ns
    always #50 i_clk = ~i_clk;

    ras_core_model core (.i_clk(i_clk), .i_op(op), .i_addr(addr),
        .i_wdata(wd), .o_call(c), .o_irq(q), .o_tref(tr), .o_tdone(td),
        .o_ret(r), .o_pwr(pw), .o_addr(ma), .o_wdata(mw));

    ras_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_call(c),
        .i_irq_accept(q), .i_table_ref(tr), .i_table_done(td), .i_ret(r),
        .i_ptr_write(pw), .i_ptr_wdata(mw), .i_return_addr(ma),
        .o_entry_index_pointer(ptr_o), .o_pc_value(pc_o),
        .o_pc_load(ld_o), .o_table_busy(busy_o));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Pre-increment save into the reference; the top index keeps nothing
    function automatic void save(input logic [15:0] a);
        ptr = ptr + 4'h1;
        if (ptr != 4'hF) begin
            mem[ptr] = a;
            vld[ptr] = 1;
        end
    endfunction

    // Restore from the reference, top index reads as 0000
    function automatic void restore();
        pcv = (ptr == 4'hF) ? 16'h0000 : mem[ptr];
        ptr = ptr - 4'h1;
    endfunction

    // One request through the core model, then compare all outputs
    task automatic do_op(input logic [2:0] o, input logic [15:0] a,
                         input logic [3:0] w);
        bit rs;
        rs = 0;
        case (o)
            3'h1, 3'h2: save(a);
            3'h3: if (!busy) begin
                save(a);
                busy = 1;
            end
            3'h4, 3'h5, 3'h7: if (o != 3'h4 || busy) begin
                restore();
                rs = 1;
                if (o == 3'h4) busy = 0;
            end
            3'h6: ptr = w;
            default: ;
        endcase
        @(posedge i_clk);
        op <= o;
        addr <= a;
        wd <= w;
        @(posedge i_clk);
        op <= 3'h0;
        @(posedge i_clk);
        #1;
        chk({12'h000, ptr_o}, {12'h000, ptr});
        chk({15'h0000, ld_o}, {15'h0000, rs});
        chk(pc_o, pcv);
        chk({15'h0000, busy_o}, {15'h0000, busy});
    endtask

    initial begin
        logic [2:0] o;
        #1;
        void'($urandom(32'h2ffd82d2));
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        #1;
        chk({12'h000, ptr_o}, 16'h000F);
        chk(pc_o, 16'h0000);
        $display("Test reset done");
        // Fill all positions, wrap past the unbacked top, then unwind
        for (int i = 0; i < 17; i++) begin
            do_op(3'h1 + i[0], 16'(16'hA000 + i), 4'h0);
        end
        for (int i = 0; i < 17; i++) do_op(3'h5, 16'h0000, 4'h0);
        $display("Test fill and unwind done");
        // Table reference, ignored repeat start, restore, ignored end
        do_op(3'h3, 16'h5A5A, 4'h0);
        do_op(3'h3, 16'h1234, 4'h0);
        do_op(3'h4, 16'h0000, 4'h0);
        do_op(3'h4, 16'h0000, 4'h0);
        $display("Test table reference done");
        // Reset in mid-run with a table reference open
        do_op(3'h3, 16'hC3C3, 4'h0);
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        ptr = 4'hF;
        pcv = 16'h0000;
        busy = 0;
        #1;
        chk({12'h000, ptr_o}, {12'h000, ptr});
        chk(pc_o, pcv);
        chk({15'h0000, busy_o}, 16'h0000);
        chk({15'h0000, ld_o}, 16'h0000);
        // Restore and save together: restore wins, entries kept
        do_op(3'h6, 16'h0000, 4'h0);
        do_op(3'h7, 16'h1111, 4'h0);
        $display("Test mid-run reset done");
        // Random calls, interrupts, returns and pointer writes
        repeat (300) begin
            o = 3'($urandom_range(1, 7));
            if (o inside {3'h3, 3'h4}) o = 3'h6;
            if ((o == 3'h5 || o == 3'h7)
                && !(ptr == 4'hF || vld[ptr])) o = 3'h1;
            do_op(o, 16'($urandom), 4'($urandom));
        end
        $display("Test random done");
        finish_test();
    end

    // Watchdog over the expected run length
    initial begin
        #(100 * 3000);
        fails++;
        finish_test();
    end
endmodule
